// ==== dv/power_fail_monitor_sequencer_bench.sv ====
// self-checking bench for the power fail monitor and sequencer
`timescale 1ns/1ps
`default_nettype none

module power_fail_monitor_sequencer_bench;
    import pfm_pkg::*;
    // short power-on delay keeps the run brief
    localparam int unsigned POR_CYC = 8;
    logic        mclk         = 1'h0;
    logic        reset        = 1'h1;
    logic        ctrl_read    = 1'h0;
    logic        ctrl_write   = 1'h0;
    logic        wdata_en     = 1'h0;
    logic        ext_reset_in = 1'h0;
    logic        clk_en       = 1'h1;
    logic [15:0] supply_mv    = 16'h1388;
    logic        below_warn, below_min, below_backup;
    logic        flag, irq_en, irq, cpu_reset, osc_en, ce_n, on_bkp, busy;
    int          fails      = 0;
    int          num_checks = 0;
    int          n;

    always #5 mclk = ~mclk;

    supply_comparator_model i_supply (
        .supply_mv(supply_mv), .below_warn(below_warn),
        .below_min(below_min), .below_backup(below_backup));

    power_fail_monitor_sequencer #(.POR_DELAY_CYCLES(POR_CYC)) i_dut (
        .mclk(mclk), .reset(reset), .clk_en(clk_en),
        .below_warn_async(below_warn), .below_min_async(below_min),
        .below_backup_async(below_backup), .ctrl_read(ctrl_read),
        .ctrl_write(ctrl_write), .ctrl_wdata_irq_enable(wdata_en),
        .ext_reset_in(ext_reset_in), .power_warn_flag(flag),
        .power_warn_irq_enable(irq_en), .power_fail_irq(irq),
        .cpu_reset(cpu_reset), .osc_enable(osc_en), .ram_ce_n(ce_n),
        .rail_on_backup(on_bkp), .por_busy(busy));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : check

    task automatic step(input int k = 1);
        repeat (k) @(posedge mclk);
        #1;
    endtask : step

    function automatic logic pick(input int sel);
        case (sel)
            0: return busy;
            1: return osc_en;
            default: return on_bkp;
        endcase
    endfunction : pick

    // bounded wait on a sequencer output
    task automatic wait_for(input int sel, input logic want);
        for (int i = 0; i < 40 && pick(sel) !== want; i++) step();
        if (pick(sel) !== want) begin
            fails++;
            $display("unexpected at %0t: wait ran out", $time);
            complete_run();
        end
    endtask : wait_for

    task automatic read_ctrl;
        @(posedge mclk);
        ctrl_read <= 1'h1;
        @(posedge mclk);
        ctrl_read <= 1'h0;
        #1;
    endtask : read_ctrl

    task automatic write_en(input logic v);
        @(posedge mclk);
        ctrl_write <= 1'h1;
        wdata_en   <= v;
        @(posedge mclk);
        ctrl_write <= 1'h0;
        #1;
    endtask : write_en

    task automatic set_supply(input logic [15:0] v);
        @(posedge mclk);
        supply_mv <= v;
        step(4);
    endtask : set_supply

    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'h0;
        step(3);
        check(flag, 1'h0, "flag after reset");
        check(irq_en, 1'h0, "enable after reset");
        check(busy, 1'h0, "busy after reset");
        check(on_bkp, 1'h0, "rail after reset");
        write_en(1'h1);
        check(irq_en, 1'h1, "enable write");
        check(irq, 1'h0, "irq without flag");
        set_supply(16'h1130);
        check(flag, 1'h1, "flag on low supply");
        check(irq, 1'h1, "irq level");
        read_ctrl();
        check(flag, 1'h1, "flag sets again while low");
        set_supply(16'h1388);
        check(flag, 1'h1, "flag holds after recovery");
        check(irq, 1'h1, "irq still pending");
        write_en(1'h0);
        check(irq, 1'h0, "irq masked");
        write_en(1'h1);
        read_ctrl();
        check(flag, 1'h0, "read clears flag");
        check(irq, 1'h0, "irq gone");
        step(6);
        check(flag, 1'h0, "flag stays clear");
        @(posedge mclk);
        ext_reset_in <= 1'h1;
        @(posedge mclk);
        ext_reset_in <= 1'h0;
        #1;
        check(cpu_reset, 1'h1, "external reset taken in run");
        check(irq_en, 1'h0, "enable cleared by reset");
        // brownout: below minimum, above switchover
        write_en(1'h1);
        @(posedge mclk);
        supply_mv <= 16'h0FA0;
        wait_for(0, 1'h1);
        check(cpu_reset, 1'h1, "cpu reset first");
        check(osc_en, 1'h1, "oscillator still on");
        check(ce_n, 1'h1, "ram disabled");
        step();
        check(irq_en, 1'h0, "enable cleared by halt");
        check(osc_en, 1'h0, "oscillator stopped next");
        check(on_bkp, 1'h0, "no switchover on brownout");
        @(posedge mclk);
        supply_mv <= 16'h1388;
        wait_for(1, 1'h1);
        n = 0;
        // reset pin held up to the last delay edge must be ignored
        for (int i = 0; i < 20 && busy === 1'h1; i++) begin
            n++;
            @(posedge mclk);
            ext_reset_in <= (i < POR_CYC - 1);
            #1;
        end
        wait_for(0, 1'h0);
        check(n == POR_CYC, 1'h1, "power-on delay length");
        check(cpu_reset, 1'h0, "reset pin ignored in delay");
        check(ce_n, 1'h0, "ram enabled after delay");
        check(flag, 1'h0, "power-on clears flag");
        // total failure down to the backup cell
        @(posedge mclk);
        supply_mv <= 16'h07D0;
        wait_for(2, 1'h1);
        check(cpu_reset, 1'h1, "halted on backup");
        step();
        check(osc_en, 1'h0, "oscillator off on backup");
        @(posedge mclk);
        supply_mv <= 16'h0DAC;
        wait_for(2, 1'h0);
        check(busy, 1'h1, "rail back to pin, still halted");
        @(posedge mclk);
        supply_mv <= 16'h1388;
        wait_for(0, 1'h0);
        check(cpu_reset, 1'h0, "run after power-on");
        check(osc_en, 1'h1, "oscillator running");
        // supply drops while the block is frozen
        @(posedge mclk);
        clk_en    <= 1'h0;
        supply_mv <= 16'h1130;
        step(5);
        check(flag, 1'h0, "flag frozen while enable low");
        @(posedge mclk);
        clk_en <= 1'h1;
        step(3);
        check(flag, 1'h1, "flag set once enabled");
        write_en(1'h1);
        check(irq, 1'h1, "irq level before reset");
        // block reset in mid-run, supply still low
        @(posedge mclk);
        reset <= 1'h1;
        repeat (2) @(posedge mclk);
        reset <= 1'h0;
        #1;
        check(flag, 1'h0, "reset clears flag");
        check(irq_en, 1'h0, "reset clears enable");
        step(3);
        check(flag, 1'h1, "flag back while still low");
        complete_run();
    end
endmodule : power_fail_monitor_sequencer_bench
`default_nettype wire

// ==== dv/supply_comparator_model.sv ====
// behavioural supply threshold comparators seen by the monitor
`timescale 1ns/1ps
`default_nettype none

module supply_comparator_model #(
    parameter int unsigned WARN_MV   = 4500,
    parameter int unsigned MIN_MV    = 4250,
    parameter int unsigned BACKUP_MV = 3000
) (
    input  wire logic [15:0] supply_mv,
    output logic             below_warn,
    output logic             below_min,
    output logic             below_backup
);
    // small delay keeps the edges off the clock, as a real comparator
    assign #3 below_warn   = (supply_mv < WARN_MV);
    assign #3 below_min    = (supply_mv < MIN_MV);
    assign #3 below_backup = (supply_mv < BACKUP_MV);
endmodule : supply_comparator_model
`default_nettype wire

// ==== rtl/pfm_pkg.sv ====
// constants and types for the power fail monitor and sequencer
package pfm_pkg;

    // synchroniser depth for the comparator indications
    localparam int unsigned SYNC_STAGES = 2;

    // oscillator stabilisation delay, in oscillator clocks
    localparam int unsigned POWER_ON_DELAY_CLOCKS = 21504;
    // one oscillator clock is one mclk cycle
    localparam int unsigned MCLK_PER_OSC_CLOCK = 1;
    localparam int unsigned POWER_ON_DELAY_CYCLES =
        POWER_ON_DELAY_CLOCKS * MCLK_PER_OSC_CLOCK;

    localparam int unsigned POR_CNT_W = 16;

    // values after reset
    localparam logic RST_WARN_FLAG  = 1'h0;
    localparam logic RST_IRQ_ENABLE = 1'h0;
    localparam logic RST_CPU_RESET  = 1'h1;
    localparam logic RST_OSC_ENABLE = 1'h1;
    localparam logic RST_RAM_CE_N   = 1'h1;
    localparam logic RST_ON_BACKUP  = 1'h0;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALT_RESET,
        ST_HALT_OSC,
        ST_POR_WAIT
    } seq_state_t;

endpackage : pfm_pkg

// ==== rtl/power_fail_monitor_sequencer.sv ====
// power fail warning flag, interrupt and power cycling sequencer
// Functional notes
// [RULE_01] Flag sets every cycle the supply is below the warning level.
// [RULE_02] Only a software read or a power-on reset clears the flag.
// [RULE_03] A clear while the supply is still low is overridden by the set.
// [RULE_04] Interrupt request is a level equal to flag AND enable.
// [RULE_05] Flag still set and enabled keeps the request up after return.
// [RULE_06] A flag cleared with the supply above warning stays clear.
// [RULE_07] Below minimum, the CPU goes to reset first, then the clock stops.
// [RULE_08] At the halt the active-low RAM chip enable is driven high.
// [RULE_09] Rail takes the backup cell below switchover, the pin above it.
// [RULE_10] Above minimum the oscillator restarts and a long delay runs.
// [RULE_11] External reset input is ignored until power-on completes.
// [RULE_12] A dip above switchover runs the same halt, rail not switched.
// [RULE_13] A control register read clears the flag; writes do nothing to it.
// [RULE_14] Interrupt enable clears on every reset, freely written otherwise.
// [RULE_15] The three comparator indications are synchronised before use.
`timescale 1ns/1ps
`default_nettype none

module power_fail_monitor_sequencer #(
    parameter int unsigned POR_DELAY_CYCLES = pfm_pkg::POWER_ON_DELAY_CYCLES
) (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic clk_en,
    input  wire logic below_warn_async,
    input  wire logic below_min_async,
    input  wire logic below_backup_async,
    input  wire logic ctrl_read,
    input  wire logic ctrl_write,
    input  wire logic ctrl_wdata_irq_enable,
    input  wire logic ext_reset_in,
    output logic      power_warn_flag,
    output logic      power_warn_irq_enable,
    output logic      power_fail_irq,
    output logic      cpu_reset,
    output logic      osc_enable,
    output logic      ram_ce_n,
    output logic      rail_on_backup,
    output logic      por_busy
);
    import pfm_pkg::*;

    localparam logic [POR_CNT_W-1:0] POR_LOAD =
        POR_CNT_W'(POR_DELAY_CYCLES - 1);

    logic [SYNC_STAGES-1:0] warn_sync_q;
    logic [SYNC_STAGES-1:0] min_sync_q;
    logic [SYNC_STAGES-1:0] backup_sync_q;
    logic                   below_warn_s;
    logic                   below_min_s;
    logic                   below_backup_s;

    seq_state_t             st_q;
    seq_state_t             st_d;
    logic [POR_CNT_W-1:0]   cnt_q;
    logic                   flag_q;
    logic                   flag_d;
    logic                   en_q;
    logic                   cpu_reset_q;
    logic                   osc_enable_q;
    logic                   ram_ce_n_q;
    logic                   on_backup_q;
    logic                   ext_rst_taken;
    logic                   flag_clear;

    // comparator synchronisers; the first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (reset) begin
            warn_sync_q   <= '0;
            min_sync_q    <= '0;
            backup_sync_q <= '0;
        end else if (clk_en) begin
            warn_sync_q   <= {warn_sync_q[SYNC_STAGES-2:0],
                              below_warn_async}; // RULE_15
            min_sync_q    <= {min_sync_q[SYNC_STAGES-2:0],
                              below_min_async}; // RULE_15
            backup_sync_q <= {backup_sync_q[SYNC_STAGES-2:0],
                              below_backup_async}; // RULE_15
        end
    end

    assign below_warn_s   = warn_sync_q[SYNC_STAGES-1];
    assign below_min_s    = min_sync_q[SYNC_STAGES-1];
    assign below_backup_s = backup_sync_q[SYNC_STAGES-1];

    // halt and power-on sequencer
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_RUN: begin
                if (below_min_s) begin
                    st_d = ST_HALT_RESET; // RULE_07
                end
            end
            ST_HALT_RESET: begin
                st_d = ST_HALT_OSC; // RULE_07
            end
            ST_HALT_OSC: begin
                if (!below_min_s) begin
                    st_d = ST_POR_WAIT; // RULE_10
                end
            end
            ST_POR_WAIT: begin
                if (below_min_s) begin
                    st_d = ST_HALT_RESET;
                end else if (cnt_q == '0) begin
                    st_d = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q <= ST_RUN;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // stabilisation count; restarts only on a fresh power-up
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            if (st_d == ST_POR_WAIT && st_q != ST_POR_WAIT) begin
                cnt_q <= POR_LOAD; // RULE_10
            end else if (st_q == ST_POR_WAIT && cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // external reset only acts once the power-on cycle is over
    assign ext_rst_taken = ext_reset_in && st_q == ST_RUN; // RULE_11

    always_ff @(posedge mclk) begin
        if (reset) begin
            cpu_reset_q  <= RST_CPU_RESET;
            osc_enable_q <= RST_OSC_ENABLE;
            ram_ce_n_q   <= RST_RAM_CE_N;
        end else if (clk_en) begin
            // reset asserts before the oscillator is stopped
            cpu_reset_q  <= (st_d != ST_RUN) || ext_rst_taken; // RULE_07
            osc_enable_q <= st_d != ST_HALT_OSC; // RULE_07 RULE_10
            ram_ce_n_q   <= st_d != ST_RUN; // RULE_08
        end
    end

    // rail switch tracks only the switchover comparator
    always_ff @(posedge mclk) begin
        if (reset) begin
            on_backup_q <= RST_ON_BACKUP;
        end else if (clk_en) begin
            on_backup_q <= below_backup_s; // RULE_09 RULE_12
        end
    end

    // clear sources: software read, or the power-on cycle itself
    assign flag_clear = ctrl_read || st_q != ST_RUN; // RULE_02 RULE_13
    // set beats clear so a low supply is never missed
    assign flag_d = below_warn_s
                 || (flag_q && !flag_clear); // RULE_01 RULE_03 RULE_06

    always_ff @(posedge mclk) begin
        if (reset) begin
            flag_q <= RST_WARN_FLAG;
        end else if (clk_en) begin
            flag_q <= flag_d;
        end
    end

    // enable bit; writes are dropped while the sequencer is out of run or an external reset is taken
    always_ff @(posedge mclk) begin
        if (reset) begin
            en_q <= RST_IRQ_ENABLE;
        end else if (clk_en) begin
            if (ext_rst_taken || st_q != ST_RUN) begin
                en_q <= RST_IRQ_ENABLE; // RULE_14
            end else if (ctrl_write) begin
                en_q <= ctrl_wdata_irq_enable; // RULE_14
            end
        end
    end

    assign power_warn_flag       = flag_q;
    assign power_warn_irq_enable = en_q;
    // level request, no edge memory: re-fires after return
    assign power_fail_irq        = flag_q && en_q; // RULE_04 RULE_05
    assign cpu_reset             = cpu_reset_q;
    assign osc_enable            = osc_enable_q;
    assign ram_ce_n              = ram_ce_n_q;
    assign rail_on_backup        = on_backup_q;
    assign por_busy              = st_q != ST_RUN;

    // every check runs on mclk and stands down while reset is high
    default clocking chk_cb @(posedge mclk);
    endclocking

    default disable iff (reset);

    sequence s_run_drop;
        st_q == ST_RUN && below_min_s && clk_en;
    endsequence

    sequence s_reset_first;
        cpu_reset_q && osc_enable_q && ram_ce_n_q;
    endsequence

    sequence s_osc_stopped;
        cpu_reset_q && !osc_enable_q && ram_ce_n_q;
    endsequence

    sequence s_last_count;
        st_q == ST_POR_WAIT && cnt_q == '0 && !below_min_s && clk_en;
    endsequence

    sequence s_released;
        st_q == ST_RUN && !cpu_reset_q && !ram_ce_n_q && osc_enable_q;
    endsequence

    warn_set_a: assert property ( // RULE_01
        (below_warn_s && clk_en) |=> flag_q
    ) else $error("warning flag not set while supply low");

    flag_hold_a: assert property ( // RULE_02
        (flag_q && !ctrl_read && st_q == ST_RUN && clk_en) |=> flag_q
    ) else $error("warning flag lost without read or power-on");

    halt_flag_clear_a: assert property ( // RULE_02
        (st_q != ST_RUN && !below_warn_s && clk_en) |=> !flag_q
    ) else $error("power-on cycle did not clear warning flag");

    read_clear_a: assert property ( // RULE_13
        (ctrl_read && !below_warn_s && clk_en) |=> !flag_q
    ) else $error("read did not clear warning flag");

    reset_reset_a: assert property ( // RULE_03
        (ctrl_read && below_warn_s && clk_en) |=> flag_q
    ) else $error("flag not set again on clear while low");

    irq_level_a: assert property ( // RULE_04
        (en_q && below_warn_s && st_q == ST_RUN && !ext_reset_in
         && !ctrl_write && clk_en) |=> power_fail_irq
    ) else $error("interrupt missing with flag and enable set");

    irq_clear_a: assert property ( // RULE_04
        (ctrl_read && !below_warn_s && clk_en) |=> !power_fail_irq
    ) else $error("interrupt still up after flag read");

    irq_refire_a: assert property ( // RULE_05
        (power_fail_irq && !ctrl_read && st_q == ST_RUN
         && !ext_reset_in && !ctrl_write && clk_en) |=> power_fail_irq
    ) else $error("interrupt dropped while flag still set");

    stay_clear_a: assert property ( // RULE_06
        (!flag_q && !below_warn_s && clk_en) |=> !flag_q
    ) else $error("flag set with supply above warning level");

    halt_order_a: assert property ( // RULE_07
        s_run_drop |=> s_reset_first
    ) else $error("oscillator stopped before cpu reset");

    osc_stop_a: assert property ( // RULE_08
        (st_q == ST_HALT_RESET && clk_en) |=> s_osc_stopped
    ) else $error("halt did not stop oscillator and ram");

    halt_ram_off_a: assert property ( // RULE_08
        st_q != ST_RUN |-> (cpu_reset_q && ram_ce_n_q)
    ) else $error("ram enabled or cpu running outside run state");

    rail_track_a: assert property ( // RULE_09
        clk_en |=> on_backup_q == $past(below_backup_s)
    ) else $error("rail source not following switchover level");

    por_count_a: assert property ( // RULE_10
        (st_q == ST_HALT_OSC && !below_min_s && clk_en) |=>
        (st_q == ST_POR_WAIT && cnt_q == POR_LOAD && osc_enable_q)
    ) else $error("power-on delay not started on supply return");

    ext_ignore_a: assert property ( // RULE_11
        (st_q == ST_POR_WAIT && cnt_q != '0 && !below_min_s && clk_en)
        |=> (cnt_q == $past(cnt_q) - 1'b1 && cpu_reset_q)
    ) else $error("power-on count disturbed during sequence");

    por_release_a: assert property ( // RULE_10 RULE_11
        s_last_count |=> s_released
    ) else $error("cpu not released at end of power-on delay");

    ext_taken_a: assert property ( // RULE_11
        (ext_reset_in && st_q == ST_RUN && clk_en) |=> (cpu_reset_q && !en_q)
    ) else $error("external reset not taken in run state");

    en_clear_a: assert property ( // RULE_14
        ((ext_rst_taken || st_q != ST_RUN) && clk_en) |=> !en_q
    ) else $error("interrupt enable survived a reset");

    // a low enable must hold every register past the synchronisers, outputs included
    freeze_hold_a: assert property (
        !clk_en |=> $stable({st_q, cnt_q, flag_q, en_q, on_backup_q,
                             cpu_reset_q, osc_enable_q, ram_ce_n_q})
    ) else $error("state moved while clock enable low");

endmodule : power_fail_monitor_sequencer

`default_nettype wire
